// >>> logic/fmtx_ctrl_master.v
// Two-wire bus master that writes and reads the FM transmitter registers.
// Assumes open-drain pads with pull-ups outside; one command at a time.
`timescale 1ns/1ps
`include "fmtx_defines.vh"
module fmtx_ctrl_master #(
    parameter QUARTER = `FMTX_QUARTER_CYC,
    parameter PUP_CYCLES = `FMTX_PUP_US * `FMTX_CYC_PER_US,
    parameter CHSW_CYCLES = `FMTX_CHSW_US * `FMTX_CYC_PER_US
)(
    input wire clk_in,
    input wire reset_n_in,
    input wire cmd_valid_in,
    input wire cmd_read_in,
    input wire [7:0] cmd_sub_addr_in,
    input wire [7:0] cmd_wdata_in,
    input wire [3:0] cmd_count_in,
    output wire cmd_ready_out,
    output wire wdata_req_out,
    output reg rdata_valid_out,
    output reg [7:0] rdata_out,
    output reg done_out,
    output reg nack_out,
    output reg device_ready_out,
    output reg [9:0] channel_index_out,
    output reg [6:0] pa_power_target_out,
    output reg tx_request_out,
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe_out,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_out
);
    localparam ST_WAIT = 4'h0;
    localparam ST_IDLE = 4'h1;
    localparam ST_START = 4'h2;
    localparam ST_BIT = 4'h3;
    localparam ST_ACK = 4'h4;
    localparam ST_STOP = 4'h5;
    localparam ST_GAP = 4'h6;
    localparam ST_DONE = 4'h7;

    // Phases: 0 addr write, 1 sub-address, 2 write data, 3 addr read, 4 read data
    localparam PH_AW = 3'h0;
    localparam PH_SUB = 3'h1;
    localparam PH_WD = 3'h2;
    localparam PH_AR = 3'h3;
    localparam PH_RD = 3'h4;

    reg [3:0] state_q;
    reg [2:0] phase_q;
    reg [1:0] quarter_q;
    reg [2:0] bit_q;
    reg [7:0] shift_q;
    reg [3:0] left_q;
    reg [7:0] ptr_q;
    reg read_q;
    reg scl_low_q;
    reg sda_low_q;
    reg [23:0] wait_q;
    reg wreq_q;
    wire tick;
    wire [1:0] pins_sync;
    wire sda_s;
    wire scl_held;

    // First byte of a transfer: address plus direction bit
    function [7:0] addr_byte;
        input dir;
        begin
            addr_byte = {`FMTX_SLAVE_ADDR, dir};
        end
    endfunction

    fmtx_pin_sync #(.WIDTH(2)) u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_sync)
    );
    assign sda_s = pins_sync[0];
    // Released clock still reads low: pause pacing so a slow slave may stretch it
    assign scl_held = !scl_low_q && !pins_sync[1];

    fmtx_tick_gen #(.DIVIDE(QUARTER)) u_tick (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .run_in(state_q != ST_WAIT && state_q != ST_IDLE && state_q != ST_DONE && !scl_held),
        .tick_out(tick)
    );

    // Open-drain: only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_out = scl_low_q;
    assign sda_oe_out = sda_low_q;
    assign cmd_ready_out = (state_q == ST_IDLE);
    assign wdata_req_out = wreq_q;

    // Main sequencer; each bit spans four ticks, SCL high in quarters 1 and 2
    always @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            state_q <= ST_WAIT;
            phase_q <= PH_AW;
            quarter_q <= 2'h0;
            bit_q <= 3'h7;
            shift_q <= 8'h00;
            left_q <= 4'h0;
            ptr_q <= 8'h00;
            read_q <= 1'b0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            wait_q <= 24'h000000;
            wreq_q <= 1'b0;
            rdata_valid_out <= 1'b0;
            rdata_out <= 8'h00;
            done_out <= 1'b0;
            nack_out <= 1'b0;
            device_ready_out <= 1'b0;
            channel_index_out <= 10'h000;
            pa_power_target_out <= 7'h00;
            tx_request_out <= 1'b0;
        end
        else
        begin
            rdata_valid_out <= 1'b0;
            done_out <= 1'b0;
            wreq_q <= 1'b0;
            case (state_q)
                ST_WAIT:
                begin
                    if (wait_q == PUP_CYCLES[23:0] - 24'h000001)
                    begin
                        state_q <= ST_IDLE;
                        device_ready_out <= 1'b1;
                        wait_q <= 24'h000000;
                    end
                    else
                        wait_q <= wait_q + 24'h000001;
                end
                ST_IDLE:
                begin
                    if (cmd_valid_in)
                    begin
                        read_q <= cmd_read_in;
                        ptr_q <= cmd_sub_addr_in;
                        left_q <= cmd_count_in;
                        nack_out <= 1'b0;
                        phase_q <= PH_AW;
                        shift_q <= addr_byte(`FMTX_DIR_WRITE);
                        state_q <= ST_START;
                        quarter_q <= 2'h0;
                    end
                end
                // start: SDA falls while SCL high
                ST_START:
                begin
                    if (tick)
                    begin
                        quarter_q <= quarter_q + 2'h1;
                        if (quarter_q == 2'h0)
                        begin
                            scl_low_q <= 1'b0;
                            sda_low_q <= 1'b0;
                        end
                        else if (quarter_q == 2'h1)
                            sda_low_q <= 1'b1;
                        else if (quarter_q == 2'h2)
                            scl_low_q <= 1'b1;
                        else
                        begin
                            state_q <= ST_BIT;
                            bit_q <= 3'h7;
                        end
                    end
                end
                // data set while SCL low, sampled while high
                ST_BIT:
                begin
                    if (tick)
                    begin
                        quarter_q <= quarter_q + 2'h1;
                        case (quarter_q)
                            2'h0:
                            begin
                                scl_low_q <= 1'b1;
                                sda_low_q <= (phase_q == PH_RD) ? 1'b0 : ~shift_q[7];
                            end
                            2'h1: scl_low_q <= 1'b0;
                            2'h2:
                            begin
                                if (phase_q == PH_RD)
                                    shift_q <= {shift_q[6:0], sda_s};
                                else
                                    shift_q <= {shift_q[6:0], 1'b0};
                            end
                            default:
                            begin
                                scl_low_q <= 1'b1;
                                if (bit_q == 3'h0)
                                    state_q <= ST_ACK;
                                else
                                    bit_q <= bit_q - 3'h1;
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    if (tick)
                    begin
                        quarter_q <= quarter_q + 2'h1;
                        case (quarter_q)
                            2'h0:
                            begin
                                scl_low_q <= 1'b1;
                                // ack read bytes, nack the last
                                sda_low_q <= (phase_q == PH_RD) && (left_q != 4'h1);
                            end
                            2'h1: scl_low_q <= 1'b0;
                            2'h2:
                            begin
                                if (phase_q == PH_RD)
                                begin
                                    rdata_out <= shift_q;
                                    rdata_valid_out <= 1'b1;
                                end
                                else if (sda_s)
                                    nack_out <= 1'b1;
                            end
                            default:
                            begin
                                scl_low_q <= 1'b1;
                                bit_q <= 3'h7;
                                state_q <= ST_BIT;
                                if (nack_out)
                                    state_q <= ST_STOP;
                                else if (phase_q == PH_AW)
                                begin
                                    phase_q <= PH_SUB;
                                    shift_q <= ptr_q;
                                end
                                else if (phase_q == PH_SUB && read_q)
                                    state_q <= ST_STOP;
                                else if (phase_q == PH_AR)
                                    phase_q <= PH_RD;
                                else if (left_q == 4'h0 || (phase_q != PH_SUB && left_q == 4'h1))
                                    state_q <= ST_STOP;
                                else
                                begin
                                    if (phase_q != PH_SUB)
                                    begin
                                        left_q <= left_q - 4'h1;
                                        ptr_q <= ptr_q + 8'h01;
                                    end
                                    if (phase_q != PH_RD)
                                    begin
                                        shift_q <= cmd_wdata_in;
                                        wreq_q <= 1'b1;
                                        phase_q <= PH_WD;
                                        if (ptr_q + {7'h00, phase_q != PH_SUB}
                                            == `FMTX_REG_SYSTEM)
                                        begin
                                            channel_index_out[`FMTX_CHAN_HI_MSB:8] <= cmd_wdata_in[1:0];
                                            tx_request_out <= cmd_wdata_in[`FMTX_TX_REQUEST_BIT];
                                        end
                                        else if (ptr_q + {7'h00, phase_q != PH_SUB}
                                            == `FMTX_REG_CHAN_LOW)
                                            channel_index_out[7:0] <= cmd_wdata_in;
                                        else if (ptr_q + {7'h00, phase_q != PH_SUB}
                                            == `FMTX_REG_PA_POWER)
                                            pa_power_target_out <= cmd_wdata_in[6:0];
                                    end
                                end
                            end
                        endcase
                    end
                end
                // stop: SDA rises while SCL high
                ST_STOP:
                begin
                    if (tick)
                    begin
                        quarter_q <= quarter_q + 2'h1;
                        if (quarter_q == 2'h0)
                        begin
                            scl_low_q <= 1'b1;
                            sda_low_q <= 1'b1;
                        end
                        else if (quarter_q == 2'h1)
                            scl_low_q <= 1'b0;
                        else if (quarter_q == 2'h2)
                            sda_low_q <= 1'b0;
                        else
                            state_q <= (read_q && phase_q == PH_SUB && !nack_out)
                                ? ST_GAP : ST_DONE;
                    end
                end
                // second read phase after bus-free gap
                ST_GAP:
                begin
                    if (wait_q == `FMTX_RESTART_CYC - 24'h000001)
                    begin
                        wait_q <= 24'h000000;
                        phase_q <= PH_AR;
                        shift_q <= addr_byte(`FMTX_DIR_READ);
                        state_q <= ST_START;
                    end
                    else
                        wait_q <= wait_q + 24'h000001;
                end
                // after a write, allow channel switch to settle before next command; reads finish at once
                ST_DONE:
                begin
                    if (wait_q == CHSW_CYCLES[23:0] - 24'h000001 || read_q)
                    begin
                        wait_q <= 24'h000000;
                        done_out <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    else
                        wait_q <= wait_q + 24'h000001;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// >>> inc/fmtx_defines.vh
// Constants for the FM transmitter two-wire control master.
// Assumes a 40 MHz system clock and open-drain pads resolved outside.
`ifndef FMTX_DEFINES_VH
`define FMTX_DEFINES_VH

`define FMTX_SLAVE_ADDR 7'h2C
`define FMTX_DIR_WRITE 1'b0
`define FMTX_DIR_READ 1'b1
`define FMTX_CLK_HZ 40000000
`define FMTX_SCL_MAX_HZ 400000
// Quarter of an SCL period in system clocks, rounded up so the bus stays slow
`define FMTX_QUARTER_CYC ((`FMTX_CLK_HZ + 4 * `FMTX_SCL_MAX_HZ - 1) / (4 * `FMTX_SCL_MAX_HZ))
// Power-up settle time 0.1 s and channel switch 10 ms, in microseconds
`define FMTX_PUP_US 100000
`define FMTX_CHSW_US 10000
`define FMTX_CYC_PER_US 40
// Bus-free time before the repeated read frame, 21.3 us in clocks
`define FMTX_RESTART_CYC 24'h000354
`define FMTX_REG_SYSTEM 8'h00
`define FMTX_REG_CHAN_LOW 8'h01
`define FMTX_REG_PA_POWER 8'h10
`define FMTX_TX_REQUEST_BIT 5
`define FMTX_CHAN_HI_MSB 9
`define FMTX_PA_MIN 7'h14
`define FMTX_PA_MAX 7'h4B
`define FMTX_PA_MASK 8'h7F

`endif

// >>> logic/fmtx_tick_gen.v
// Quarter-period enable for the two-wire bus clock.
// Assumes one system clock; the tick is a one-cycle pulse.
`timescale 1ns/1ps
module fmtx_tick_gen #(
    parameter DIVIDE = 25
)(
    input wire clk_in,
    input wire reset_n_in,
    input wire run_in,
    output reg tick_out
);
    reg [15:0] count_q;

    // Counter restarts while idle so each bit begins on a full phase
    always @(posedge clk_in)
    begin
        if (!reset_n_in || !run_in)
        begin
            count_q <= 16'h0000;
            tick_out <= 1'b0;
        end
        else if (count_q == DIVIDE[15:0] - 16'h0001)
        begin
            count_q <= 16'h0000;
            tick_out <= 1'b1;
        end
        else
        begin
            count_q <= count_q + 16'h0001;
            tick_out <= 1'b0;
        end
    end
endmodule

// >>> logic/fmtx_pin_sync.v
// Two-flop synchroniser for pad inputs.
// Assumes inputs are asynchronous to clk_in.
`timescale 1ns/1ps
module fmtx_pin_sync #(
    parameter WIDTH = 2
)(
    input wire clk_in,
    input wire reset_n_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;

    // Idle bus lines are high, so reset to ones
    always @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            meta_q <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// >>> testbench/fmtx_ctrl_master_asserts.sv
// Concurrent checks on the two-wire master pins and command handshake.
// Assumes one clock domain; bound to every fmtx_ctrl_master instance.
`timescale 1ns/1ps
module fmtx_ctrl_master_asserts #(
    parameter PUP_CYCLES = 100,
    parameter CHSW_CYCLES = 50
)(
    input wire clk_in,
    input wire reset_n_in,
    input wire cmd_valid_in,
    input wire cmd_read_in,
    input wire cmd_ready_out,
    input wire rdata_valid_out,
    input wire done_out,
    input wire nack_out,
    input wire scl_oe_out,
    input wire sda_oe_out
);
    // Clock-fall spacing for 400 kbit/s at 40 MHz, less one
    localparam MIN_PER = 99;
    reg [15:0] per_q;
    reg [15:0] up_q;
    reg [15:0] stp_q;
    reg rd_q;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // Saturating counters; saturation keeps long idle gaps from wrapping
    always @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            per_q <= 16'hFFFF;
            up_q <= 16'h0000;
            stp_q <= 16'h0000;
            rd_q <= 1'b0;
        end
        else
        begin
            per_q <= $rose(scl_oe_out) ? 16'h0000 : per_q + {15'h0000, per_q != 16'hFFFF};
            up_q <= up_q + {15'h0000, up_q != 16'hFFFF};
            stp_q <= (!scl_oe_out && $fell(sda_oe_out)) ? 16'h0000
                : stp_q + {15'h0000, stp_q != 16'hFFFF};
            if (cmd_valid_in && cmd_ready_out)
                rd_q <= cmd_read_in;
        end
    end
    bus_rate_a: assert property ($rose(scl_oe_out) |-> per_q >= MIN_PER)
        else $error("bus clock faster than allowed");
    start_clock_a: assert property ($rose(sda_oe_out) && !scl_oe_out |-> ##[1:200] scl_oe_out)
        else $error("start not followed by clock low");
    stop_idle_a: assert property ($fell(sda_oe_out) && !scl_oe_out |-> !scl_oe_out [*8])
        else $error("clock pulled right after stop");
    reset_quiet_a: assert property ($rose(reset_n_in) |-> !cmd_ready_out && !scl_oe_out && !sda_oe_out)
        else $error("lines or ready active after reset");
    pup_wait_a: assert property (cmd_ready_out |-> up_q >= PUP_CYCLES - 1)
        else $error("ready before power-up wait");
    chsw_wait_a: assert property (done_out && !rd_q && !nack_out |-> stp_q >= CHSW_CYCLES - 1)
        else $error("write done before switch wait");
    busy_refuse_a: assert property (cmd_valid_in && cmd_ready_out |=> !cmd_ready_out [*4])
        else $error("ready while busy");
    done_pulse_a: assert property (done_out |=> !done_out)
        else $error("done longer than one cycle");
    nack_stop_a: assert property ($rose(nack_out) |-> ##[1:300] (!scl_oe_out && $fell(sda_oe_out)))
        else $error("no release after missing ack");
    cover property (done_out && !rd_q);
    cover property (rdata_valid_out);
    cover property ($rose(nack_out));
endmodule
bind fmtx_ctrl_master fmtx_ctrl_master_asserts #(
    .PUP_CYCLES(PUP_CYCLES),
    .CHSW_CYCLES(CHSW_CYCLES)
) chk (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .cmd_valid_in(cmd_valid_in),
    .cmd_read_in(cmd_read_in),
    .cmd_ready_out(cmd_ready_out),
    .rdata_valid_out(rdata_valid_out),
    .done_out(done_out),
    .nack_out(nack_out),
    .scl_oe_out(scl_oe_out),
    .sda_oe_out(sda_oe_out)
);

// >>> testbench/fmtx_dev_model.sv
// Behavioural two-wire slave standing in for the transmitter registers.
// Assumes pull-ups on both lines; sda_oe_out high pulls data low.
`timescale 1ns/1ps
module fmtx_dev_model #(
    parameter ADDR = 7'h2C,
    parameter SILENCE_NS = 200000
)(
    input wire scl_in,
    input wire sda_in,
    input wire nak_in,
    output reg sda_oe_out
);
    reg [7:0] mem [0:255];
    reg [7:0] sh, tx, ptr, first_q;
    reg [3:0] bn;
    reg [1:0] ph;
    reg act, rd, ok, mack;
    reg tx_on;
    reg [6:0] pa_applied;
    integer i, sent;
    initial
    begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = 8'h00;
        mem[0] = 8'h01;
        sda_oe_out = 1'b0;
        act = 1'b0;
        first_q = 8'h00;
        sent = 0;
        tx_on = 1'b0;
        pa_applied = 7'h00;
    end
    always @(negedge sda_in)
        if (scl_in)
        begin
            act = 1'b1;
            bn = 4'h0;
            ph = 2'h0;
            rd = 1'b0;
            sent = 0;
        end
    // no audio reaches this model, so transmit drops a fixed time after it starts
    always @(posedge tx_on)
    begin
        #SILENCE_NS;
        tx_on = 1'b0;
    end
    always @(posedge sda_in)
        if (scl_in)
            act = 1'b0;
    always @(posedge scl_in)
        if (act)
        begin
            if (bn < 4'h8)
                sh = {sh[6:0], sda_in};
            else
                mack = !sda_in;
            bn = bn + 4'h1;
        end
    // Drive a little after the clock falls so data never moves with it high
    always @(negedge scl_in)
        if (act)
        begin
            #100;
            if (bn == 4'h8)
            begin
                sda_oe_out = 1'b0;
                if (!rd)
                begin
                    if (ph == 2'h0)
                        first_q = sh;
                    if (ph == 2'h0)
                        ok = (sh[7:1] == ADDR) && !nak_in;
                    else if (ph == 2'h1)
                        ptr = sh;
                    else
                    begin
                        // stored power target applies on entering transmit or a new channel
                        if ((ptr == 8'h00 && (sh[1:0] != mem[0][1:0] || (sh[5] && !mem[0][5])))
                            || (ptr == 8'h01 && sh != mem[1]))
                            pa_applied = mem[16][6:0];
                        if (ptr == 8'h00)
                            tx_on = sh[5];
                        mem[ptr] = sh;
                    end
                    if (ph == 2'h2)
                        ptr = ptr + 8'h01;
                    sda_oe_out = ok;
                    if (ph != 2'h2)
                        ph = ph + 2'h1;
                end
            end
            else if (bn == 4'h9)
            begin
                bn = 4'h0;
                sda_oe_out = 1'b0;
                // next byte on ack, release on not-ack
                if (ok && first_q[0] && (!rd || mack))
                begin
                    rd = 1'b1;
                    tx = mem[ptr];
                    ptr = ptr + 8'h01;
                    sent = sent + 1;
                    sda_oe_out = !tx[7];
                end
                else if (!ok || rd)
                    act = 1'b0;
            end
            else if (rd)
                sda_oe_out = !tx[7 - bn];
        end
endmodule

// >>> testbench/test_fmtx_ctrl_master.sv
// Self-checking bench: master against the behavioural slave model.
// Assumes pull-ups resolve both lines from all open-drain enables.
`timescale 1ns/1ps
module test_fmtx_ctrl_master;
    localparam LIM = 60000;
    reg clk_in, reset_n_in, cmd_valid, cmd_read, nak;
    reg [7:0] cmd_sub, cmd_wdata;
    reg [3:0] cmd_cnt;
    wire cmd_ready_out, wdata_req_out, rdata_valid_out, done_out, nack_out;
    wire device_ready_out, tx_request_out, scl_oe, sda_oe, dev_oe, scl_o, sda_o;
    wire [7:0] rdata_out;
    wire [9:0] channel_index_out;
    wire [6:0] pa_power_target_out;
    // Wired-AND bus levels
    wire scl = !scl_oe;
    wire sda = !(sda_oe | dev_oe);
    reg [7:0] rbuf [0:15];
    integer failures, total_checks, nr, i;
    fmtx_ctrl_master #(.QUARTER(25), .PUP_CYCLES(100), .CHSW_CYCLES(50)) DUT (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid),
        .cmd_read_in(cmd_read), .cmd_sub_addr_in(cmd_sub), .cmd_wdata_in(cmd_wdata),
        .cmd_count_in(cmd_cnt), .cmd_ready_out(cmd_ready_out), .wdata_req_out(wdata_req_out),
        .rdata_valid_out(rdata_valid_out), .rdata_out(rdata_out), .done_out(done_out),
        .nack_out(nack_out), .device_ready_out(device_ready_out),
        .channel_index_out(channel_index_out), .pa_power_target_out(pa_power_target_out),
        .tx_request_out(tx_request_out), .scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe));
    fmtx_dev_model dev (.scl_in(scl), .sda_in(sda), .nak_in(nak), .sda_oe_out(dev_oe));
    // 40 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = !clk_in;
    end
    task wrap_up;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk_field(input logic [9:0] got, input logic [9:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
                failures = failures + 1;
            if (got !== exp)
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_byte(input logic [7:0] got, input logic [7:0] exp);
        chk_field({2'h0, got}, {2'h0, exp});
    endtask
    task chk_flag(input logic got, input logic exp);
        chk_field({9'h000, got}, {9'h000, exp});
    endtask
    // Bounded waits; a spent bound ends the run as a failure
    task wait_done(input logic rdy);
        integer n;
        begin
            n = 0;
            while ((rdy ? cmd_ready_out : done_out) !== 1'b1 && n < LIM)
            begin
                @(negedge clk_in);
                n = n + 1;
                if (wdata_req_out === 1'b1)
                    @(posedge clk_in) cmd_wdata <= cmd_wdata + 8'h01;
                if (rdata_valid_out === 1'b1 && nr < 16)
                    rbuf[nr] = rdata_out;
                if (rdata_valid_out === 1'b1)
                    nr = nr + 1;
            end
            if (n >= LIM)
                failures = failures + 1;
            if (n >= LIM)
                wrap_up;
        end
    endtask
    // One whole command; write bytes count up from base
    task run_cmd(input logic rd, input logic [7:0] sub, input logic [3:0] cnt,
                 input logic [7:0] base);
        begin
            nr = 0;
            @(posedge clk_in);
            cmd_valid <= 1'b1;
            cmd_read <= rd;
            cmd_sub <= sub;
            cmd_cnt <= cnt;
            cmd_wdata <= base;
            @(negedge clk_in);
            wait_done(1'b1);
            @(posedge clk_in) cmd_valid <= 1'b0;
            wait_done(1'b0);
        end
    endtask
    task t_power_up;
        begin
            @(negedge clk_in);
            chk_flag(cmd_ready_out, 1'b0);
            chk_byte(dev.mem[0], 8'h01);
            wait_done(1'b1);
            chk_flag(device_ready_out, 1'b1);
            $display("test power_up done");
        end
    endtask
    task t_write_regs;
        begin
            run_cmd(1'b0, 8'h00, 4'h2, 8'h22);
            chk_byte(dev.first_q, 8'h58);
            chk_byte(dev.mem[0], 8'h22);
            chk_byte(dev.mem[1], 8'h23);
            chk_field(channel_index_out, 10'h223);
            chk_flag(tx_request_out, 1'b1);
            chk_flag(nack_out, 1'b0);
            run_cmd(1'b0, 8'h10, 4'h1, 8'hCB);
            chk_field({3'h0, pa_power_target_out}, 10'h04B);
            chk_byte(dev.mem[16], 8'hCB);
            chk_byte({1'b0, dev.pa_applied}, 8'h00);
            chk_flag(dev.tx_on, 1'b1);
            $display("test write_regs done");
        end
    endtask
    task t_read_back;
        begin
            run_cmd(1'b1, 8'h00, 4'h2, 8'h00);
            chk_byte(dev.first_q, 8'h59);
            chk_field(nr[9:0], 10'h002);
            chk_field(dev.sent[9:0], 10'h002);
            chk_byte(rbuf[0], 8'h22);
            chk_byte(rbuf[1], 8'h23);
            $display("test read_back done");
        end
    endtask
    task t_long_burst;
        begin
            run_cmd(1'b0, 8'h20, 4'hF, 8'hA0);
            run_cmd(1'b1, 8'h20, 4'hF, 8'h00);
            chk_field(dev.sent[9:0], 10'h00F);
            for (i = 0; i < 15; i = i + 1)
                chk_byte(rbuf[i], 8'hA0 + i[7:0]);
            chk_flag(dev.tx_on, 1'b0);
            $display("test long_burst done");
        end
    endtask
    task t_no_ack;
        begin
            @(posedge clk_in) nak <= 1'b1;
            run_cmd(1'b0, 8'h01, 4'h1, 8'h77);
            chk_flag(nack_out, 1'b1);
            chk_byte(dev.mem[1], 8'h23);
            @(posedge clk_in) nak <= 1'b0;
            run_cmd(1'b1, 8'h01, 4'h1, 8'h00);
            chk_flag(nack_out, 1'b0);
            chk_byte(rbuf[0], 8'h23);
            $display("test no_ack done");
        end
    endtask
    task t_power_apply;
        begin
            run_cmd(1'b0, 8'h01, 4'h1, 8'h30);
            chk_field(channel_index_out, 10'h230);
            chk_byte({1'b0, dev.pa_applied}, 8'h4B);
            $display("test power_apply done");
        end
    endtask
    // Main sequence
    initial
    begin
        failures = 0;
        total_checks = 0;
        reset_n_in = 1'b0;
        cmd_valid = 1'b0;
        cmd_read = 1'b0;
        cmd_sub = 8'h00;
        cmd_wdata = 8'h00;
        cmd_cnt = 4'h1;
        nak = 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_power_up;
        t_write_regs;
        t_read_back;
        t_long_burst;
        t_no_ack;
        t_power_apply;
        wrap_up;
    end
endmodule
